// >>> rtl/blsc_color_sel.sv
// blsc_color_sel.sv: picks pattern and source colours and trims
// them to the engine colour depth.
// assumes: all inputs come from registers on the same clock.
`timescale 1ns/1ps
`include "blsc_regs.svh"

module blsc_color_sel (
  input  wire logic                  clock,     // 100 MHz
  input  wire logic                  rstn,      // async reset, low
  input  wire blsc_pkg::blsc_depth_e depth,     // effective depth
  input  wire logic                  srcSel,    // use dedicated src colours
  input  wire blsc_pkg::blsc_color_t sharedBg,  // shared background
  input  wire blsc_pkg::blsc_color_t sharedFg,  // shared foreground
  input  wire blsc_pkg::blsc_color_t srcBg,     // dedicated src background
  input  wire blsc_pkg::blsc_color_t srcFg,     // dedicated src foreground
  output logic      [23:0]           patBgOut,  // pattern background
  output logic      [23:0]           patFgOut,  // pattern foreground
  output logic      [23:0]           srcBgOut,  // source background
  output logic      [23:0]           srcFgOut   // source foreground
);
  import blsc_pkg::*;

  // byte mask of one depth; reserved code keeps only the low byte
  function automatic logic [23:0] depthMask(input blsc_depth_e d);
    case (d)
      BLSC_DEPTH_16: depthMask = `BLSC_CMASK_16BPP;
      BLSC_DEPTH_24: depthMask = `BLSC_CMASK_24BPP;
      default:       depthMask = `BLSC_CMASK_8BPP;
    endcase
  endfunction

  logic [23:0] patBg_r, patFg_r, srcBg_r, srcFg_r; // outputs
  logic [23:0] patBg_nxt, patFg_nxt, srcBg_nxt, srcFg_nxt; // next
  logic [23:0] mask; // depth mask

  ////////////////////////////////////////////////////////////////////////
  // pattern uses shared pair; source follows select
  always_comb begin
    mask      = depthMask(depth);
    patBg_nxt = sharedBg & mask;
    patFg_nxt = sharedFg & mask;
    if (srcSel) begin
      srcBg_nxt = srcBg & mask;
      srcFg_nxt = srcFg & mask;
    end else begin
      srcBg_nxt = sharedBg & mask;
      srcFg_nxt = sharedFg & mask;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      patBg_r <= 24'h00_0000;
      patFg_r <= 24'h00_0000;
      srcBg_r <= 24'h00_0000;
      srcFg_r <= 24'h00_0000;
    end else begin
      patBg_r <= patBg_nxt;
      patFg_r <= patFg_nxt;
      srcBg_r <= srcBg_nxt;
      srcFg_r <= srcFg_nxt;
    end
  end

  assign patBgOut = patBg_r;
  assign patFgOut = patFg_r;
  assign srcBgOut = srcBg_r;
  assign srcFgOut = srcFg_r;

endmodule // blsc_color_sel

// >>> rtl/blsc_line_step.sv
// blsc_line_step.sv: holds a current line address and steps it by a
// 13-bit stride once per line.
// assumes: load and step are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`include "blsc_regs.svh"

module blsc_line_step (
  input  wire logic                  clock,     // 100 MHz
  input  wire logic                  rstn,      // async reset, low
  input  wire logic                  load,      // take loadValue
  input  wire blsc_pkg::blsc_word_t  loadValue, // start address
  input  wire logic                  step,      // advance one line
  input  wire blsc_pkg::blsc_stride_t stride,   // bytes per line step
  output logic      [31:0]           lineAddr   // current line start
);
  import blsc_pkg::*;

  logic [31:0] addr_r;   // current line address
  logic [31:0] addr_nxt; // its next value

  ////////////////////////////////////////////////////////////////////////
  // load wins over step so a fresh operation never starts one line late
  always_comb begin
    addr_nxt = addr_r;
    if (load) begin
      addr_nxt = loadValue;
    end else if (step) begin
      addr_nxt = addr_r + {19'h0_0000, stride}; // wraps at 4 GB
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_r <= `BLSC_RESET_ADDR;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  assign lineAddr = addr_r;

endmodule // blsc_line_step

// >>> rtl/blsc_pkg.sv
// blsc_pkg.sv: types shared by the stride and colour register bank.
// assumes: included constants come from blsc_regs.svh.
package blsc_pkg;

  // engine colour depth code
  typedef enum logic [1:0] {
    BLSC_DEPTH_8   = 2'b00,
    BLSC_DEPTH_16  = 2'b01,
    BLSC_DEPTH_24  = 2'b10,
    BLSC_DEPTH_RSV = 2'b11
  } blsc_depth_e;

  // kind of source operand of the running operation
  typedef enum logic [1:0] {
    BLSC_SRC_NONE  = 2'b00,
    BLSC_SRC_MONO  = 2'b01,
    BLSC_SRC_FB    = 2'b10,
    BLSC_SRC_HOST  = 2'b11
  } blsc_src_e;

  typedef logic [31:0] blsc_word_t;
  typedef logic [23:0] blsc_color_t;
  typedef logic [12:0] blsc_stride_t;

endpackage : blsc_pkg

// >>> rtl/blsc_regs.svh
// blsc_regs.svh: offsets, fields, masks and resets of the
// stride and colour register bank.
// assumes: offsets are byte offsets within the 16 MB host-bus memory space.
`ifndef BLSC_REGS_SVH
`define BLSC_REGS_SVH

// register bank sits 4 MB above the memory-space base
`define BLSC_BANK_BASE 24'h40_0000
`define BLSC_NUM_REGS 11
// byte offsets inside the memory space
`define BLSC_OFF_LINE_STRIDE 24'h40_0000
`define BLSC_OFF_SHARED_BG 24'h40_0004
`define BLSC_OFF_SHARED_FG 24'h40_0008
`define BLSC_OFF_MONO_CTRL 24'h40_000C
`define BLSC_OFF_ENGINE_CTRL 24'h40_0010
`define BLSC_OFF_PAT_ADDR 24'h40_0014
`define BLSC_OFF_SRC_ADDR 24'h40_0018
`define BLSC_OFF_DST_ADDR 24'h40_001C
`define BLSC_OFF_DST_EXTENT 24'h40_0020
`define BLSC_OFF_SRC_BG 24'h40_0024
`define BLSC_OFF_SRC_FG 24'h40_0028
// register indices
`define BLSC_IDX_LINE_STRIDE 4'd0
`define BLSC_IDX_SHARED_BG 4'd1
`define BLSC_IDX_SHARED_FG 4'd2
`define BLSC_IDX_MONO_CTRL 4'd3
`define BLSC_IDX_ENGINE_CTRL 4'd4
`define BLSC_IDX_SRC_BG 4'd9
`define BLSC_IDX_SRC_FG 4'd10
// stride fields
`define BLSC_DST_STRIDE_LSB 16
`define BLSC_DST_STRIDE_MSB 28
`define BLSC_SRC_STRIDE_LSB 0
`define BLSC_SRC_STRIDE_MSB 12
// colour, select and depth fields
`define BLSC_COLOR_MSB 23
`define BLSC_SRC_COLOR_SEL 27
`define BLSC_DEPTH_LSB 24
`define BLSC_DEPTH_MSB 25
`define BLSC_DEPTH_CTRL 23
`define BLSC_BUSY_BIT 31
// writable masks
`define BLSC_MASK_STRIDE 32'h1FFF_1FFF
`define BLSC_MASK_COLOR 32'h00FF_FFFF
`define BLSC_MASK_MONO_CTRL 32'h0F3F_3F3F
`define BLSC_MASK_ENGINE_CTRL 32'h03FF_FFFF
`define BLSC_MASK_FULL 32'hFFFF_FFFF
// reset values
`define BLSC_RESET_VALUE 32'h0000_0000
`define BLSC_RESET_ADDR 32'h0000_0000
// colour byte masks per depth
`define BLSC_CMASK_8BPP 24'h00_00FF
`define BLSC_CMASK_16BPP 24'h00_FFFF
`define BLSC_CMASK_24BPP 24'hFF_FFFF

`endif

// >>> rtl/blsc_stride_color_regs.sv
// blsc_stride_color_regs.sv: register bank of the block-transfer engine,
// with line stepping and colour choice.
// assumes: host-bus cycles arrive decoded to this device's
// 16 MB space as a byte offset with byte enables, on the same clock.
`timescale 1ns/1ps
`include "blsc_regs.svh"

module blsc_stride_color_regs (
  input  wire logic                  clock,       // 100 MHz
  input  wire logic                  rstn,        // async reset, low
  // host-bus register port
  input  wire logic [23:0]           hostAddr,    // byte offset in space
  input  wire logic [3:0]            hostByteEn,  // byte enables, high
  input  wire logic                  hostWrite,   // write strobe
  input  wire logic                  hostRead,    // read strobe
  input  wire logic [31:0]           hostWdata,   // write data
  output logic      [31:0]           hostRdata,   // read data
  output logic                       hostRvalid,  // read data valid
  output logic                       hostHit,     // access is for bank
  output logic                       hostSizeErr, // refused access size
  // engine side
  input  wire blsc_pkg::blsc_depth_e cfgDepth,    // depth from config reg
  input  wire logic                  engineBusy,  // engine running
  input  wire blsc_pkg::blsc_src_e   srcKind,     // source operand kind
  input  wire logic                  opStart,     // load line addresses
  input  wire logic                  dstLineDone, // destination line end
  input  wire logic                  srcLineDone, // source line end
  output logic      [31:0]           dstLineAddr, // dest line start
  output logic      [31:0]           srcLineAddr, // src line start/offset
  output logic      [31:0]           patAddr,     // pattern address
  output logic      [31:0]           dstExtent,   // width and height
  output logic      [31:0]           monoCtrl,    // mono source control
  output logic      [31:0]           engineCtrl,  // engine control
  output logic      [23:0]           patBgColor,  // pattern background
  output logic      [23:0]           patFgColor,  // pattern foreground
  output logic      [23:0]           srcBgColor,  // source background
  output logic      [23:0]           srcFgColor   // source foreground
);
  import blsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // register index, all ones when unmapped
  function automatic logic [3:0] regIndex(input logic [23:0] a);
    logic [3:0] idx;
    // unmapped unless matched
    idx = 4'hF;
    if (a == `BLSC_OFF_LINE_STRIDE) begin
      idx = 4'd0;
    end else if (a == `BLSC_OFF_SHARED_BG) begin
      idx = 4'd1;
    end else if (a == `BLSC_OFF_SHARED_FG) begin
      idx = 4'd2;
    end else if (a == `BLSC_OFF_MONO_CTRL) begin
      idx = 4'd3;
    end else if (a == `BLSC_OFF_ENGINE_CTRL) begin
      idx = 4'd4;
    end else if (a == `BLSC_OFF_PAT_ADDR) begin
      idx = 4'd5;
    end else if (a == `BLSC_OFF_SRC_ADDR) begin
      idx = 4'd6;
    end else if (a == `BLSC_OFF_DST_ADDR) begin
      idx = 4'd7;
    end else if (a == `BLSC_OFF_DST_EXTENT) begin
      idx = 4'd8;
    end else if (a == `BLSC_OFF_SRC_BG) begin
      idx = 4'd9;
    end else if (a == `BLSC_OFF_SRC_FG) begin
      idx = 4'd10;
    end
    regIndex = idx;
  endfunction

  // writable bits of one register
  function automatic logic [31:0] writeMask(input logic [3:0] idx);
    logic [31:0] m;
    m = `BLSC_MASK_FULL;
    if (idx == `BLSC_IDX_LINE_STRIDE) begin
      m = `BLSC_MASK_STRIDE;
    end else if (idx == `BLSC_IDX_SHARED_BG || idx == `BLSC_IDX_SHARED_FG ||
                 idx == `BLSC_IDX_SRC_BG || idx == `BLSC_IDX_SRC_FG) begin
      m = `BLSC_MASK_COLOR;
    end else if (idx == `BLSC_IDX_MONO_CTRL) begin
      m = `BLSC_MASK_MONO_CTRL;
    end else if (idx == `BLSC_IDX_ENGINE_CTRL) begin
      m = `BLSC_MASK_ENGINE_CTRL;
    end
    writeMask = m;
  endfunction

  // byte enables as a bit mask
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // access decode

  // decode results
  logic [3:0]  accIdx;     // addressed register index
  logic        accMapped;  // address hits one of the eleven
  logic        accSizeOk;  // one aligned half word or a whole word
  logic        accGo;      // access is taken

  // byte and three-byte enables are refused; halves must be aligned
  always_comb begin
    accIdx    = regIndex(hostAddr);
    accMapped = (accIdx != 4'hF);
    accSizeOk = (hostByteEn == 4'b1111) ||
                (hostByteEn == 4'b0011) ||
                (hostByteEn == 4'b1100);
    accGo     = accMapped && accSizeOk;
  end

  // handshakes are combinational
  assign hostHit     = accMapped && (hostWrite || hostRead);
  assign hostSizeErr = accMapped && (hostWrite || hostRead) && !accSizeOk;

  ////////////////////////////////////////////////////////////////////////
  // register storage

  // bank words
  logic [31:0] regFile_r   [0:`BLSC_NUM_REGS-1]; // stored words
  logic [31:0] regFile_nxt [0:`BLSC_NUM_REGS-1]; // their next values
  logic [31:0] wrMask;                           // lanes and live bits

  // only live bits in enabled lanes change
  always_comb begin
    for (int i = 0; i < `BLSC_NUM_REGS; i++) begin
      regFile_nxt[i] = regFile_r[i];
    end
    wrMask = writeMask(accIdx) & laneMask(hostByteEn);
    if (hostWrite && accGo) begin
      regFile_nxt[accIdx] = (regFile_r[accIdx] & ~wrMask) |
                            (hostWdata & wrMask);
    end
  end

  // register the bank
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `BLSC_NUM_REGS; i++) begin
        regFile_r[i] <= `BLSC_RESET_VALUE;
      end
    end else begin
      for (int i = 0; i < `BLSC_NUM_REGS; i++) begin
        regFile_r[i] <= regFile_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  // answer state
  logic [31:0] rdata_r;   // registered read data
  logic [31:0] rdata_nxt; // its next value
  logic        rvalid_r;  // read answer pulse
  logic        rvalid_nxt;

  // storage holds zero in unused bits; busy is live
  // a half access sees only its half
  always_comb begin
    rdata_nxt  = 32'h0000_0000;
    rvalid_nxt = 1'b0;
    if (hostRead && accGo) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = regFile_r[accIdx];
      if (accIdx == `BLSC_IDX_ENGINE_CTRL) begin
        rdata_nxt[`BLSC_BUSY_BIT] = engineBusy;
      end
      rdata_nxt = rdata_nxt & laneMask(hostByteEn);
    end // unmapped reads: another decoder answers
  end

  // register the answer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // read answer ports
  assign hostRdata  = rdata_r;
  assign hostRvalid = rvalid_r;

  ////////////////////////////////////////////////////////////////////////
  // effective colour depth

  // register views used below
  logic [31:0] ctrlWord;   // engine control register
  logic [31:0] strideWord; // stride register
  blsc_depth_e depthSel;   // depth used for colour trimming

  // ctrl bit 23 picks its own depth over the config one
  always_comb begin
    ctrlWord   = regFile_r[`BLSC_IDX_ENGINE_CTRL];
    strideWord = regFile_r[`BLSC_IDX_LINE_STRIDE];
    if (ctrlWord[`BLSC_DEPTH_CTRL]) begin
      depthSel = blsc_depth_e'(ctrlWord[`BLSC_DEPTH_MSB:`BLSC_DEPTH_LSB]);
    end else begin
      depthSel = cfgDepth;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line stepping

  // source step gating
  logic        srcStepEn;  // source stride in use
  logic [31:0] srcBase;    // source start: frame address or stream zero

  // mono or absent source never steps; a host-fed
  // source counts stream bytes from offset zero
  always_comb begin
    srcStepEn = srcLineDone &&
                ((srcKind == BLSC_SRC_FB) ||
                 (srcKind == BLSC_SRC_HOST));
    if (srcKind == BLSC_SRC_HOST) begin
      srcBase = 32'h0000_0000;
    end else begin
      srcBase = regFile_r[6];
    end
  end

  // destination pointer steps by bits 28-16
  blsc_line_step dstStep (
    .clock     (clock),
    .rstn      (rstn),
    .load      (opStart),
    .loadValue (regFile_r[7]),
    .step      (dstLineDone),
    .stride    (strideWord[`BLSC_DST_STRIDE_MSB:`BLSC_DST_STRIDE_LSB]),
    .lineAddr  (dstLineAddr)
  );

  // source pointer steps by bits 12-0
  blsc_line_step srcStep (
    .clock     (clock),
    .rstn      (rstn),
    .load      (opStart),
    .loadValue (srcBase),
    .step      (srcStepEn),
    .stride    (strideWord[`BLSC_SRC_STRIDE_MSB:`BLSC_SRC_STRIDE_LSB]),
    .lineAddr  (srcLineAddr)
  );

  ////////////////////////////////////////////////////////////////////////
  // expansion colours

  logic [31:0] monoWord; // mono source control register

  // mono control word
  always_comb begin
    monoWord = regFile_r[`BLSC_IDX_MONO_CTRL];
  end

  // registered trim and routing stage
  blsc_color_sel colorSel (
    .clock    (clock),
    .rstn     (rstn),
    .depth    (depthSel),
    .srcSel   (monoWord[`BLSC_SRC_COLOR_SEL]),
    .sharedBg (regFile_r[`BLSC_IDX_SHARED_BG][`BLSC_COLOR_MSB:0]),
    .sharedFg (regFile_r[`BLSC_IDX_SHARED_FG][`BLSC_COLOR_MSB:0]),
    .srcBg    (regFile_r[`BLSC_IDX_SRC_BG][`BLSC_COLOR_MSB:0]),
    .srcFg    (regFile_r[`BLSC_IDX_SRC_FG][`BLSC_COLOR_MSB:0]),
    .patBgOut (patBgColor),
    .patFgOut (patFgColor),
    .srcBgOut (srcBgColor),
    .srcFgOut (srcFgColor)
  );

  ////////////////////////////////////////////////////////////////////////
  // plain register views

  assign patAddr    = regFile_r[5];
  assign dstExtent  = regFile_r[8];
  assign monoCtrl   = monoWord;
  assign engineCtrl = ctrlWord;

endmodule // blsc_stride_color_regs

// >>> tb/blsc_host_model.sv
// blsc_host_model.sv: host cpu model issuing register accesses.
// assumes: shares the bank clock; the bench calls its access task.
`timescale 1ns/1ps

module blsc_host_model (
  input  wire logic        clock,       // bus clock
  input  wire logic [31:0] hostRdata,   // read data
  input  wire logic        hostRvalid,  // read answer
  input  wire logic        hostHit,     // decode hit
  input  wire logic        hostSizeErr, // size refused
  output logic      [23:0] hostAddr,    // byte offset
  output logic      [3:0]  hostByteEn,  // lanes
  output logic             hostWrite,   // write strobe
  output logic             hostRead,    // read strobe
  output logic      [31:0] hostWdata    // write data
);
  logic hitSeen; // decode at the taking edge
  logic errSeen; // refusal at the taking edge

  initial begin
    hostWrite = 1'b0;
    hostRead = 1'b0;
  end

  // one access over one edge; released lines show inverse values
  task automatic access(input logic wr, input logic [23:0] a,
                        input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] q, output logic v);
    @(posedge clock);
    #1;
    hostAddr = a;
    hostByteEn = be;
    hostWdata = d;
    hostWrite = wr;
    hostRead = !wr;
    @(posedge clock);
    hitSeen = hostHit;
    errSeen = hostSizeErr;
    #1;
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostAddr = ~a;
    hostByteEn = ~be;
    hostWdata = ~d;
    q = hostRdata;
    v = hostRvalid;
  endtask
endmodule // blsc_host_model

// >>> tb/blsc_regs_chk_sva.sv
// blsc_regs_chk_sva.sv: port checker for the stride and colour bank.
// assumes: bound to the bank top; one clock, async low reset.
`timescale 1ns/1ps

module blsc_regs_chk
  import blsc_pkg::*;
(
  input wire logic        clock,       // bus clock
  input wire logic        rstn,        // async reset, low
  input wire logic [23:0] hostAddr,    // byte offset
  input wire logic [3:0]  hostByteEn,  // lanes
  input wire logic        hostWrite,   // write strobe
  input wire logic        hostRead,    // read strobe
  input wire logic [31:0] hostWdata,   // write data
  input wire logic [31:0] hostRdata,   // read data
  input wire logic        hostRvalid,  // read answer
  input wire logic        hostHit,     // decode hit
  input wire logic        hostSizeErr, // size refused
  input wire blsc_depth_e cfgDepth,    // config depth
  input wire blsc_src_e   srcKind,     // source kind
  input wire logic        opStart,     // line address load
  input wire logic        dstLineDone, // dest line step
  input wire logic        srcLineDone, // source line step
  input wire logic [31:0] dstLineAddr, // dest line start
  input wire logic [31:0] srcLineAddr, // source line start
  input wire logic [31:0] engineCtrl,  // engine control view
  input wire logic [23:0] patBgColor,  // pattern background
  input wire logic [23:0] srcBgColor   // source background
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] stride_r;   // shadow of the stride register
  logic [31:0] stride_nxt; // its next value
  logic [31:0] laneMask;   // enabled byte lanes
  logic [1:0]  effDepth;   // trim depth

  // stride shadow, lane by lane
  always_comb begin
    laneMask = {{8{hostByteEn[3]}}, {8{hostByteEn[2]}},
                {8{hostByteEn[1]}}, {8{hostByteEn[0]}}};
    stride_nxt = stride_r;
    if (hostWrite && hostHit && !hostSizeErr && hostAddr == 24'h40_0000)
      stride_nxt = (stride_r & ~laneMask) | (hostWdata & laneMask
                   & 32'h1FFF_1FFF);
    effDepth = engineCtrl[23] ? engineCtrl[25:24] : cfgDepth;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) stride_r <= 32'h0000_0000;
    else stride_r <= stride_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  sequence readTaken;
    hostRead && hostHit && !hostSizeErr;
  endsequence
  sequence dstStep;
    dstLineDone && !opStart;
  endsequence
  sequence srcStep;
    srcLineDone && !opStart;
  endsequence

  chk_hit_decode: assert property (hostHit == ((hostWrite || hostRead)
    && hostAddr >= 24'h40_0000 && hostAddr <= 24'h40_0028
    && hostAddr[1:0] == 2'b00)) else $error("bank decode wrong");
  chk_size_refuse: assert property (hostSizeErr == (hostHit
    && !(hostByteEn inside {4'hF, 4'h3, 4'hC})))
    else $error("size refusal wrong");
  chk_read_answer: assert property (readTaken |=> hostRvalid)
    else $error("read not answered");
  chk_no_answer: assert property (!readTaken |=> !hostRvalid)
    else $error("answer without read");
  chk_stride_rsv: assert property (hostRvalid
    && $past(hostAddr) == 24'h40_0000 |-> hostRdata[31:29] == 3'b000
    && hostRdata[15:13] == 3'b000) else $error("stride spare bits set");
  chk_color_rsv: assert property (hostRvalid && $past(hostAddr) inside
    {24'h40_0004, 24'h40_0008, 24'h40_0024, 24'h40_0028}
    |-> hostRdata[31:24] == 8'h00) else $error("colour top byte set");
  chk_dst_step: assert property (dstStep |=> dstLineAddr ==
    $past(dstLineAddr) + {19'b0, $past(stride_r[28:16])})
    else $error("dest line step wrong");
  chk_src_step: assert property (srcStep ##0 srcKind[1] |=>
    srcLineAddr == $past(srcLineAddr) + {19'b0, $past(stride_r[12:0])})
    else $error("source line step wrong");
  chk_src_ignore: assert property (srcStep ##0 !srcKind[1]
    |=> $stable(srcLineAddr)) else $error("source stride not ignored");
  chk_host_origin: assert property (opStart && srcKind == BLSC_SRC_HOST
    |=> srcLineAddr == 32'h0000_0000) else $error("stream offset not 0");
  chk_depth_trim: assert property ($past(effDepth) != 2'b10
    |-> patBgColor[23:16] == 8'h00 && srcBgColor[23:16] == 8'h00)
    else $error("colour not trimmed");
endmodule // blsc_regs_chk

bind blsc_stride_color_regs blsc_regs_chk chk (.clock, .rstn, .hostAddr,
  .hostByteEn, .hostWrite, .hostRead, .hostWdata, .hostRdata, .hostRvalid,
  .hostHit, .hostSizeErr, .cfgDepth, .srcKind, .opStart, .dstLineDone,
  .srcLineDone, .dstLineAddr, .srcLineAddr, .engineCtrl, .patBgColor,
  .srcBgColor);

// >>> tb/tb.sv
// tb.sv: self-checking bench for the stride and colour register bank.
// assumes: host model drives the bus, bench drives the engine side.
`timescale 1ns/1ps
`include "blsc_regs.svh"

module tb;
  import blsc_pkg::*;
  logic        clock = 1'b0; // 100 MHz
  logic        rstn = 1'b0; // reset, low
  logic [23:0] hostAddr; // model outputs
  logic [3:0]  hostByteEn;
  logic        hostWrite, hostRead;
  logic [31:0] hostWdata, hostRdata, rq;
  logic        hostRvalid, hostHit, hostSizeErr, rv;
  blsc_depth_e cfgDepth = BLSC_DEPTH_8;
  blsc_src_e   srcKind = BLSC_SRC_NONE;
  logic        engineBusy = 1'b0, opStart = 1'b0;
  logic        dstLineDone = 1'b0, srcLineDone = 1'b0;
  logic [31:0] dstLineAddr, srcLineAddr, engineCtrl, patAddr, dstExtent;
  logic [31:0] monoCtrl;
  logic [23:0] patBgColor, patFgColor, srcBgColor, srcFgColor;
  int          nErrors = 0, nCompared = 0, cycles = 0;

  always #5 clock = ~clock;

  blsc_host_model host (.clock, .hostRdata, .hostRvalid, .hostHit,
    .hostSizeErr, .hostAddr, .hostByteEn, .hostWrite, .hostRead,
    .hostWdata);
  blsc_stride_color_regs dut (.clock, .rstn, .hostAddr, .hostByteEn,
    .hostWrite, .hostRead, .hostWdata, .hostRdata, .hostRvalid, .hostHit,
    .hostSizeErr, .cfgDepth, .engineBusy, .srcKind, .opStart, .dstLineDone,
    .srcLineDone, .dstLineAddr, .srcLineAddr, .patAddr, .dstExtent,
    .monoCtrl, .engineCtrl, .patBgColor, .patFgColor, .srcBgColor,
    .srcFgColor);

  ////////////////////////////////////////////////////////////////////////
  // writable bits per index
  function automatic logic [31:0] wmask(input int i);
    case (i)
      0: return `BLSC_MASK_STRIDE;
      1, 2, 9, 10: return `BLSC_MASK_COLOR;
      3: return `BLSC_MASK_MONO_CTRL;
      4: return `BLSC_MASK_ENGINE_CTRL;
      default: return `BLSC_MASK_FULL;
    endcase
  endfunction

  // colour bytes kept per depth
  function automatic logic [23:0] cmask(input logic [1:0] d);
    if (d == 2'b01) return `BLSC_CMASK_16BPP;
    if (d == 2'b10) return `BLSC_CMASK_24BPP;
    return `BLSC_CMASK_8BPP;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nCompared++;
    if (seen !== want) begin
      nErrors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    host.access(1'b1, a, be, d, rq, rv);
  endtask

  task automatic rd(input logic [23:0] a, input logic [3:0] be);
    host.access(1'b0, a, be, 32'h0000_0000, rq, rv);
  endtask

  task automatic giveVerdict();
    if (nErrors == 0 && nCompared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, far above the run's length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      giveVerdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d [11];
    logic [31:0] st, da, sa, e;
    logic [3:0]  bad [3];
    bad = '{4'h1, 4'h7, 4'hE};
    void'($urandom(10));
    repeat (12) @(posedge clock);
    #1 rstn = 1'b1;
    // all read zero after reset
    for (int i = 0; i < 11; i++) begin
      rd(`BLSC_BANK_BASE + 24'(4 * i), 4'hF);
      check(rq, 32'h0000_0000);
    end
    repeat (3) begin
      // full-word writes, masked readback
      for (int i = 0; i < 11; i++) begin
        d[i] = $urandom();
        wr(`BLSC_BANK_BASE + 24'(4 * i), 4'hF, d[i]);
        check({31'b0, host.hitSeen}, 32'h1);
      end
      engineBusy = 1'b1;
      for (int i = 0; i < 11; i++) begin
        rd(`BLSC_BANK_BASE + 24'(4 * i), 4'hF);
        check(rq, (d[i] & wmask(i)) | {i == 4, 31'b0});
      end
      check(patAddr, d[5]);
      check(dstExtent, d[8]);
      check(monoCtrl, d[3] & wmask(3));
      check(engineCtrl, d[4] & wmask(4));
      engineBusy = 1'b0;
      // half words, refused sizes, unmapped places
      e = $urandom();
      wr(`BLSC_OFF_LINE_STRIDE, 4'h3, e);
      rd(`BLSC_OFF_LINE_STRIDE, 4'hC);
      check(rq, d[0] & 32'h1FFF_0000);
      for (int k = 0; k < 3; k++) begin
        wr(`BLSC_OFF_SHARED_BG, bad[k], e);
        check({31'b0, host.errSeen}, 32'h1);
      end
      rd(`BLSC_OFF_SHARED_BG, 4'h3);
      check(rq, d[1] & 32'h0000_FFFF);
      wr(24'h40_002C, 4'hF, e);
      check({31'b0, host.hitSeen}, 32'h0);
      rd(24'h3F_FFFC, 4'hF);
      check({31'b0, rv}, 32'h0);
      // stepping per source kind
      st = $urandom() & `BLSC_MASK_STRIDE;
      da = $urandom();
      sa = $urandom();
      wr(`BLSC_OFF_LINE_STRIDE, 4'hF, st);
      wr(`BLSC_OFF_DST_ADDR, 4'hF, da);
      wr(`BLSC_OFF_SRC_ADDR, 4'hF, sa);
      for (int k = 0; k < 4; k++) begin
        srcKind = blsc_src_e'(k);
        opStart = 1'b1;
        @(posedge clock);
        #1 opStart = 1'b0;
        dstLineDone = 1'b1;
        srcLineDone = 1'b1;
        repeat (3) @(posedge clock);
        #1 dstLineDone = 1'b0;
        srcLineDone = 1'b0;
        check(dstLineAddr, da + 3 * st[28:16]);
        check(srcLineAddr, (k == 3 ? 0 : sa) +
              (k > 1 ? 3 * st[12:0] : 0));
      end
      // colour over select and depth
      for (int s = 0; s < 2; s++) begin
        wr(`BLSC_OFF_MONO_CTRL, 4'hF, {4'h0, s[0], 27'h0});
        for (int m = 0; m < 8; m++) begin
          wr(`BLSC_OFF_ENGINE_CTRL, 4'hF, {6'h0, m[1:0], m[2], 23'h0});
          cfgDepth = blsc_depth_e'(m[2] ? ~m[1:0] : m[1:0]);
          repeat (2) @(posedge clock);
          #1;
          check(patBgColor, d[1][23:0] & cmask(m[1:0]));
          check(patFgColor, d[2][23:0] & cmask(m[1:0]));
          check(srcBgColor, d[s ? 9 : 1][23:0] & cmask(m[1:0]));
          check(srcFgColor, d[s ? 10 : 2][23:0] & cmask(m[1:0]));
        end
      end
    end
    giveVerdict();
  end
endmodule // tb
